// >>> src/ebf_pkg.sv
// Package for the event buffer word formatter: word layout, codes, map.
// Assumes one clock domain and a single user of these definitions.
package ebf_pkg;
  // ----------------------------------------------------------------
  // Window and word layout
  // ----------------------------------------------------------------
  localparam logic [15:0] EBF_WIN_LO      = 16'h0000;
  localparam logic [15:0] EBF_WIN_HI      = 16'h0FFC;
  localparam logic [2:0]  EBF_TYPE_HDR    = 3'h2;
  localparam logic [2:0]  EBF_TYPE_DAT    = 3'h0;
  localparam logic [2:0]  EBF_TYPE_EOB    = 3'h4;
  localparam logic [2:0]  EBF_TYPE_INV    = 3'h6;
  localparam int          EBF_NCH         = 32;
  localparam int          EBF_HALF        = 16;
  localparam int          EBF_FIFO_DEPTH  = 8;
  localparam int          EBF_FIFO_WIDTH  = 32;
  localparam int          EBF_BS2_OVR_BIT = 3;
  localparam int          EBF_BS2_UND_BIT = 4;
  localparam int          EBF_BS2_INV_BIT = 5;
  localparam logic [23:0] EBF_EVCNT_RST   = 24'h00_0000;

  // One converted channel as delivered by the conversion logic
  typedef struct packed {
    logic        valid;
    logic        under;
    logic        over;
    logic [11:0] value;
  } ebf_chan_s;

  // Module-wide settings steering the formatter
  typedef struct packed {
    logic [4:0]  slot;
    logic [7:0]  crate;
    logic [15:0] bitset2;
    logic        narrow;   // 16-channel variant
  } ebf_cfg_s;

  typedef enum logic [3:0] {
    EBF_IDLE = 4'b0001,
    EBF_HDR  = 4'b0010,
    EBF_DAT  = 4'b0100,
    EBF_EOB  = 4'b1000
  } ebf_state_e;
endpackage : ebf_pkg

// >>> src/ebf_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides.
// Assumes a single clock and active-low asynchronous reset.
module ebf_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,      // Module clock
  input  wire logic             nrst,     // Async reset, active low
  input  wire logic [WIDTH-1:0] in_data,  // Write data
  input  wire logic             in_valid, // Write request
  output logic                  in_ready, // Not full
  output logic      [WIDTH-1:0] out_data, // Head word
  output logic                  out_valid,// Not empty
  input  wire logic             out_ready // Pop
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
  } ebf_fifo_s;

  ebf_fifo_s st_r;
  ebf_fifo_s st_nxt;
  logic      push;
  logic      pop;

  // ----------------------------------------------------------------
  // Flags and handshakes
  // ----------------------------------------------------------------
  assign in_ready  = (st_r.cnt != (AW+1)'(DEPTH));
  assign out_valid = (st_r.cnt != '0);
  assign out_data  = st_r.mem[st_r.rp];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  // Next-state: pointers wrap at DEPTH, which need not be a power of two
  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.mem[st_r.wp] = in_data;
      st_nxt.wp = (st_r.wp == AW'(DEPTH-1)) ? '0 : st_r.wp + 1'b1;
    end
    if (pop) begin
      st_nxt.rp = (st_r.rp == AW'(DEPTH-1)) ? '0 : st_r.rp + 1'b1;
    end
    st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  // State register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule // ebf_fifo

// >>> src/ebf_formatter.sv
// Event formatter: builds header/data/trailer words into a FIFO and serves
// them as read-only 32-bit words through the readout window.
// Assumes channel values and flags are stable from gate_done until busy falls.
// How it works
// - Window 0x0000..0x0FFC is read-only; each read returns the next stored word.
// - Each event is one header, one or more data words, one trailer.
// - Slot code sits in bits 31:27 of all words except the filler.
// - Type in bits 26:24: 010 header, 000 data, 100 trailer, 110 invalid.
// - Header bits 23:16 carry the crate number from the crate register.
// - Header bits 13:8 carry the count of data words in the event.
// - Data channel in bits 20:16, or 20:17 on the 16-channel variant.
// - Bit 14 is valid; invalid data kept only if control bit 5 set.
// - Bit 13 is below-threshold; kept only if control bit 4 set.
// - Bit 12 is overflow; overflowed data kept only if control bit 3 set.
// - Bits 11:0 hold the 12-bit converted value.
// - Trailer bits 23:0 carry the 24-bit event counter.
// - Reading an empty buffer returns a filler word of type 110.
// - Channels stored interleaved: 0,16,1,17.. or 0,8,1,9.. on 16 channels.
// - Suppressed or disabled channels are skipped, others keep their order.
// - A gate with no surviving channel writes no event at all.
// - Trailer written only after all data words of the event.
module ebf_formatter
  import ebf_pkg::*;
(
  input  wire logic                      clk,        // 200 MHz module clock
  input  wire logic                      nrst,       // Async reset, active low
  input  wire ebf_cfg_s                  cfg,        // Slot, crate, bit-set 2, variant
  input  wire logic [EBF_NCH-1:0]        chan_en,    // Per-channel user enable
  input  wire ebf_chan_s [EBF_NCH-1:0]   chan,       // Converted channel data
  input  wire logic                      gate_done,  // Pulse: conversion finished
  input  wire logic                      ev_inc,     // Pulse: count one event
  input  wire logic                      ev_clr,     // Pulse: clear event counter
  output logic                           busy,       // Formatter owns the channel data
  input  wire logic                      rd_stb,     // Read strobe, one cycle
  input  wire logic [15:0]               rd_addr,    // Byte offset of the read
  output logic [31:0]                    rd_data,    // Read data, registered
  output logic                           rd_ack,     // Read answered, pulse
  output logic                           data_ready  // At least one word stored
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    ebf_state_e            fsm;
    logic [EBF_NCH-1:0]    keep;     // Latched survivors of this gate
    logic [4:0]            slot_idx; // Position in storage sequence
    logic [5:0]            cnt;      // Data words for header
    logic [23:0]           evcnt;
    logic [31:0]           rdata;
    logic                  ack;
  } ebf_st_s;

  ebf_st_s    st_r;
  ebf_st_s    st_nxt;
  logic [31:0] w_data;
  logic        w_valid;
  logic        w_ready;
  logic [31:0] q_data;
  logic        q_valid;
  logic        q_pop;
  logic [EBF_NCH-1:0] surv;
  logic [4:0]  seq_ch [EBF_NCH];
  logic [4:0]  cur_ch;
  logic [5:0]  nsurv;
  logic        win_hit;
  logic        last_pos;

  // ----------------------------------------------------------------
  // Channel filter and storage order
  // ----------------------------------------------------------------
  // Survivor mask and sequence position to channel map, one per channel
  genvar g;
  generate
    for (g = 0; g < EBF_NCH; g++) begin : g_ch
      assign surv[g] = chan_en[g]
        & (chan[g].valid | cfg.bitset2[EBF_BS2_INV_BIT])
        & (!chan[g].under | cfg.bitset2[EBF_BS2_UND_BIT])
        & (!chan[g].over | cfg.bitset2[EBF_BS2_OVR_BIT])
        & (!cfg.narrow | (g < EBF_HALF));
      // Even positions take the lower half, odd ones the upper half
      assign seq_ch[g] = (g % 2 == 0) ? 5'(g / 2)
                       : (cfg.narrow ? 5'(g / 2 + 8) : 5'(g / 2 + 16));
    end
  endgenerate

  // Survivor count, known before the header is written
  always_comb begin
    nsurv = '0;
    for (int i = 0; i < EBF_NCH; i++) begin
      nsurv = nsurv + 6'(surv[i]);
    end
  end

  assign cur_ch   = seq_ch[st_r.slot_idx];
  assign last_pos = cfg.narrow ? (st_r.slot_idx == 5'd15) : (st_r.slot_idx == 5'd31);
  assign busy     = (st_r.fsm != EBF_IDLE);

  // ----------------------------------------------------------------
  // Word assembly
  // ----------------------------------------------------------------
  // Unused fields stay zero by construction of each word
  always_comb begin
    w_data  = '0;
    w_valid = 1'b0;
    case (st_r.fsm)
      EBF_HDR: begin
        w_valid = 1'b1;
        w_data  = {cfg.slot, EBF_TYPE_HDR, cfg.crate, 2'b00,
                   st_r.cnt, 8'h00};
      end
      EBF_DAT: begin
        w_valid = st_r.keep[cur_ch];
        w_data[31:27] = cfg.slot;
        w_data[26:24] = EBF_TYPE_DAT;
        if (cfg.narrow) begin
          w_data[20:17] = cur_ch[3:0];
        end else begin
          w_data[20:16] = cur_ch;
        end
        w_data[14]   = chan[cur_ch].valid;
        w_data[13]   = chan[cur_ch].under;
        w_data[12]   = chan[cur_ch].over;
        w_data[11:0] = chan[cur_ch].value;
      end
      EBF_EOB: begin
        w_valid = 1'b1;
        w_data  = {cfg.slot, EBF_TYPE_EOB, st_r.evcnt};
      end
      default: begin
        w_valid = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Event sequencer and readout
  // ----------------------------------------------------------------
  assign win_hit = (rd_addr >= EBF_WIN_LO) && (rd_addr <= EBF_WIN_HI)
                 && (rd_addr[1:0] == 2'b00);
  assign q_pop   = rd_stb & win_hit & q_valid;

  // Sequencer stalls on a full FIFO, so back-pressure reaches the gate
  always_comb begin
    st_nxt     = st_r;
    st_nxt.ack = rd_stb;
    if (ev_clr) begin
      st_nxt.evcnt = EBF_EVCNT_RST;
    end else if (ev_inc) begin
      st_nxt.evcnt = st_r.evcnt + 24'h00_0001;
    end
    case (st_r.fsm)
      EBF_IDLE: begin
        // Empty gates leave no trace in the store
        if (gate_done && (nsurv != '0)) begin
          st_nxt.fsm      = EBF_HDR;
          st_nxt.keep     = surv;
          st_nxt.cnt      = nsurv;
          st_nxt.slot_idx = '0;
        end
      end
      EBF_HDR: begin
        if (w_ready) begin
          st_nxt.fsm = EBF_DAT;
        end
      end
      EBF_DAT: begin
        if (!w_valid || w_ready) begin
          st_nxt.slot_idx = st_r.slot_idx + 5'd1;
          if (last_pos) begin
            st_nxt.fsm = EBF_EOB;
          end
        end
      end
      EBF_EOB: begin
        if (w_ready) begin
          st_nxt.fsm = EBF_IDLE;
        end
      end
      default: begin
        st_nxt.fsm = EBF_IDLE;
      end
    endcase
    // Reads outside the window or on an empty store give the filler
    if (q_pop) begin
      st_nxt.rdata = q_data;
    end else if (rd_stb) begin
      st_nxt.rdata = {5'h00, EBF_TYPE_INV, 24'h00_0000};
    end
  end

  // State register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_r     <= '0;
      st_r.fsm <= EBF_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rd_data    = st_r.rdata;
  assign rd_ack     = st_r.ack;
  assign data_ready = q_valid;

  ebf_fifo #(
    .WIDTH (EBF_FIFO_WIDTH),
    .DEPTH (EBF_FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .nrst      (nrst),
    .in_data   (w_data),
    .in_valid  (w_valid),
    .in_ready  (w_ready),
    .out_data  (q_data),
    .out_valid (q_valid),
    .out_ready (q_pop)
  );

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_empty_filler;
    @(posedge clk) disable iff (!nrst)
      (rd_stb && !q_valid) |=> (rd_data == 32'h0600_0000);
  endproperty
  a_empty_filler: assert property (p_empty_filler) else $error("empty read not filler");

  property p_pop_data;
    @(posedge clk) disable iff (!nrst)
      q_pop |=> (rd_data == $past(q_data));
  endproperty
  a_pop_data: assert property (p_pop_data) else $error("read data not head word");

  property p_hdr_fmt;
    @(posedge clk) disable iff (!nrst)
      (st_r.fsm == EBF_HDR) |-> (w_data[26:24] == 3'b010 && w_data[31:27] == cfg.slot
                                 && w_data[23:16] == cfg.crate && w_data[15:14] == 2'b00);
  endproperty
  a_hdr_fmt: assert property (p_hdr_fmt) else $error("header layout wrong");

  property p_hdr_cnt;
    @(posedge clk) disable iff (!nrst)
      (st_r.fsm == EBF_IDLE && gate_done && nsurv != 0) |=> (w_data[13:8] == $past(nsurv));
  endproperty
  a_hdr_cnt: assert property (p_hdr_cnt) else $error("header count wrong");

  property p_eob_fmt;
    @(posedge clk) disable iff (!nrst)
      (st_r.fsm == EBF_EOB) |-> (w_data == {cfg.slot, 3'b100, st_r.evcnt});
  endproperty
  a_eob_fmt: assert property (p_eob_fmt) else $error("trailer layout wrong");

  property p_dat_fmt;
    @(posedge clk) disable iff (!nrst)
      (st_r.fsm == EBF_DAT && w_valid) |-> (w_data[26:24] == 3'b000 && w_data[15] == 1'b0
                                            && w_data[23:21] == 3'b000);
  endproperty
  a_dat_fmt: assert property (p_dat_fmt) else $error("data layout wrong");

  property p_no_empty_event;
    @(posedge clk) disable iff (!nrst)
      (st_r.fsm == EBF_IDLE && gate_done && nsurv == 0) |=> (st_r.fsm == EBF_IDLE);
  endproperty
  a_no_empty_event: assert property (p_no_empty_event) else $error("empty gate stored");

  property p_eob_after_dat;
    @(posedge clk) disable iff (!nrst)
      (st_r.fsm == EBF_EOB) |-> ($past(st_r.fsm) inside {EBF_DAT, EBF_EOB});
  endproperty
  a_eob_after_dat: assert property (p_eob_after_dat) else $error("trailer before data");

  property p_keep_filter;
    @(posedge clk) disable iff (!nrst)
      (st_r.fsm == EBF_DAT && w_valid && !cfg.bitset2[EBF_BS2_OVR_BIT]) |-> !w_data[12];
  endproperty
  a_keep_filter: assert property (p_keep_filter) else $error("overflow stored");

  property p_ack_follows;
    @(posedge clk) disable iff (!nrst)
      rd_stb |=> rd_ack;
  endproperty
  a_ack_follows: assert property (p_ack_follows) else $error("read not answered");

  property p_rdata_hold;
    @(posedge clk) disable iff (!nrst)
      !rd_stb |=> $stable(rd_data);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

  property p_win_miss;
    @(posedge clk) disable iff (!nrst)
      (rd_stb && !win_hit) |=> (rd_data == 32'h0600_0000);
  endproperty
  a_win_miss: assert property (p_win_miss) else $error("miss read not filler");

  property p_hdr_open;
    @(posedge clk) disable iff (!nrst)
      (st_r.fsm == EBF_IDLE && gate_done && nsurv != 6'h00) |=> (st_r.fsm == EBF_HDR);
  endproperty
  a_hdr_open: assert property (p_hdr_open) else $error("event not opened");

  property p_cnt_keep;
    @(posedge clk) disable iff (!nrst)
      (st_r.fsm == EBF_HDR) |-> ($countones(st_r.keep) == int'(st_r.cnt));
  endproperty
  a_cnt_keep: assert property (p_cnt_keep) else $error("count off survivors");

  property p_dat_slot;
    @(posedge clk) disable iff (!nrst)
      (st_r.fsm == EBF_DAT && w_valid) |-> (w_data[31:27] == cfg.slot);
  endproperty
  a_dat_slot: assert property (p_dat_slot) else $error("data slot wrong");

  // Interleave checked by a bit shuffle, independent of the lookup table
  property p_seq_order;
    @(posedge clk) disable iff (!nrst)
      (st_r.fsm == EBF_DAT) |-> (cur_ch == (cfg.narrow
        ? {1'b0, st_r.slot_idx[0], st_r.slot_idx[3:1]}
        : {st_r.slot_idx[0], st_r.slot_idx[4:1]}));
  endproperty
  a_seq_order: assert property (p_seq_order) else $error("channel order wrong");

  property p_under_filter;
    @(posedge clk) disable iff (!nrst)
      (st_r.fsm == EBF_DAT && w_valid && !cfg.bitset2[EBF_BS2_UND_BIT]) |-> !w_data[13];
  endproperty
  a_under_filter: assert property (p_under_filter) else $error("below level stored");

  property p_inv_filter;
    @(posedge clk) disable iff (!nrst)
      (st_r.fsm == EBF_DAT && w_valid && !cfg.bitset2[EBF_BS2_INV_BIT]) |-> w_data[14];
  endproperty
  a_inv_filter: assert property (p_inv_filter) else $error("invalid stored");

  property p_narrow_pad;
    @(posedge clk) disable iff (!nrst)
      (st_r.fsm == EBF_DAT && w_valid && cfg.narrow) |-> !w_data[16];
  endproperty
  a_narrow_pad: assert property (p_narrow_pad) else $error("narrow pad bit set");

  property p_evcnt_clr;
    @(posedge clk) disable iff (!nrst)
      ev_clr |=> (st_r.evcnt == EBF_EVCNT_RST);
  endproperty
  a_evcnt_clr: assert property (p_evcnt_clr) else $error("counter not cleared");

  // Survivors stay latched for the whole event, so late gates change nothing
  property p_keep_stable;
    @(posedge clk) disable iff (!nrst)
      busy |=> $stable(st_r.keep);
  endproperty
  a_keep_stable: assert property (p_keep_stable) else $error("survivors changed");
endmodule // ebf_formatter

// >>> testbench/ebf_reader.sv
// Partner model: the reader on the far side of the readout window.
// Assumes one strobe per read and an answer within a few cycles.
module ebf_reader (
  input  wire logic        clk,     // Module clock
  input  wire logic        rd_ack,  // Answer pulse
  input  wire logic [31:0] rd_data, // Answer word
  output logic             rd_stb,  // Read strobe, one cycle
  output logic      [15:0] rd_addr  // Byte offset
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    rd_stb  = 1'b0;
    rd_addr = 16'h0000;
  end
  // ----------------------------------------------------------------
  // One read cycle
  // ----------------------------------------------------------------
  // A held strobe would be taken as a second read, so it drops after one
  // cycle; the offset is then inverted so nothing leans on a stale value
  task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic ok);
    @(posedge clk);
    rd_stb  <= 1'b1;
    rd_addr <= a;
    @(posedge clk);
    rd_stb  <= 1'b0;
    rd_addr <= ~a;
    ok = 1'b0;
    d  = 32'h0000_0000;
    for (int n = 0; n < 4 && !ok; n++) begin
      @(posedge clk);
      ok = (rd_ack === 1'b1);
      d  = rd_data;
    end
  endtask
endmodule // ebf_reader

// >>> testbench/tb_event_buffer_word_formatter.sv
// Bench for the event formatter: random events against a queue model.
// Assumes the reader model answers every read within four cycles.
module tb_event_buffer_word_formatter import ebf_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] FILL = 32'h0600_0000;
  logic                  clk = 1'b0;
  logic                  nrst;
  ebf_cfg_s              cfg;
  logic [EBF_NCH-1:0]    chan_en;
  ebf_chan_s [EBF_NCH-1:0] chan;
  logic                  gate_done, ev_inc, ev_clr, busy, rd_stb, rd_ack, data_ready;
  logic [15:0]           rd_addr;
  logic [31:0]           rd_data;
  logic [31:0]           q[$];
  logic [23:0]           evc = 24'h00_0000;
  int                    errors = 0, num_checks = 0, cycles = 0;

  always #2.5 clk = ~clk;

  ebf_formatter dut_u (.clk(clk), .nrst(nrst), .cfg(cfg), .chan_en(chan_en), .chan(chan),
    .gate_done(gate_done), .ev_inc(ev_inc), .ev_clr(ev_clr), .busy(busy), .rd_stb(rd_stb),
    .rd_addr(rd_addr), .rd_data(rd_data), .rd_ack(rd_ack), .data_ready(data_ready));
  ebf_reader rdr_u (.clk(clk), .rd_ack(rd_ack), .rd_data(rd_data), .rd_stb(rd_stb),
    .rd_addr(rd_addr));

  // ----------------------------------------------------------------
  // Comparisons and closing
  // ----------------------------------------------------------------
  task automatic chk_w(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic chk_b(input logic g, input logic e);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic rdchk(input logic [15:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic        ok;
    rdr_u.rd(a, d, ok);
    chk_b(ok, 1'b1);
    chk_w(d, e);
  endtask
  // Counter pulses; a clear beside an increment must win
  task automatic bump(input logic i, input logic c);
    @(posedge clk);
    ev_inc <= i;
    ev_clr <= c;
    evc = c ? 24'h00_0000 : evc + 24'(i);
    @(posedge clk);
    ev_inc <= 1'b0;
    ev_clr <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // One gate: model, stall check, bad reads, drain
  // ----------------------------------------------------------------
  task automatic ev(input logic nw, input logic [31:0] en, input logic [15:0] bs);
    ebf_chan_s   cv[32];
    logic [31:0] d[$];
    logic [4:0]  sl;
    logic [7:0]  cr;
    int          c;
    int          tot;
    sl = 5'($urandom);
    cr = 8'($urandom);
    @(posedge clk);
    cfg     <= '{slot: sl, crate: cr, bitset2: bs, narrow: nw};
    chan_en <= en;
    for (int i = 0; i < 32; i++) begin
      cv[i] = ebf_chan_s'(15'($urandom));
      chan[i] <= cv[i];
    end
    for (int p = 0; p < (nw ? 16 : 32); p++) begin
      c = (p % 2 == 1) ? p / 2 + (nw ? 8 : 16) : p / 2;
      if (en[c] && (cv[c].valid || bs[5]) && (!cv[c].under || bs[4]) && (!cv[c].over || bs[3]))
        d.push_back({sl, 3'b000, 3'b000, nw ? {c[3:0], 1'b0} : c[4:0], 1'b0, cv[c].valid,
                     cv[c].under, cv[c].over, cv[c].value});
    end
    if (d.size() > 0) begin
      q.push_back({sl, 3'b010, cr, 2'b00, 6'(d.size()), 8'h00});
      foreach (d[i]) q.push_back(d[i]);
      q.push_back({sl, 3'b100, evc});
    end
    tot = q.size();
    // Second gate pulse lands while busy and must add nothing
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      gate_done <= ~k[0];
    end
    // Reader stalls: more than eight words keep the writer waiting
    repeat (40) @(posedge clk);
    chk_b(busy, tot > 8);
    chk_b(data_ready, tot > 0);
    if (tot > 0) begin
      rdchk(16'h1000, FILL);
      rdchk(16'h0FFE, FILL);
    end
    while (q.size() > 0 && errors < 20) begin
      c = 0;
      while (data_ready !== 1'b1 && c < 200) begin
        @(posedge clk);
        c++;
      end
      rdchk({4'h0, 12'($urandom) & 12'hFFC}, q.pop_front());
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    cfg       = '0;
    chan_en   = '0;
    chan      = '0;
    gate_done = 1'b0;
    ev_inc    = 1'b0;
    ev_clr    = 1'b0;
    nrst      = 1'b0;
    void'($urandom(32'h38d4));
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    chk_b(busy, 1'b0);
    chk_b(data_ready, 1'b0);
    rdchk(16'h0000, FILL);
    bump(1'b1, 1'b0);
    bump(1'b1, 1'b0);
    ev(1'b0, 32'hFFFF_FFFF, 16'h0038);
    ev(1'b1, 32'hFFFF_FFFF, 16'h0038);
    ev(1'b0, 32'h0000_0000, 16'h0038);
    bump(1'b1, 1'b1);
    for (int k = 0; k < 12; k++) begin
      bump(1'b1, 1'b0);
      ev(k[0], $urandom, 16'($urandom));
    end
    rdchk(16'h0004, FILL);
    conclude;
  end

  // Hang guard, well above the one to two thousand cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      conclude;
    end
  end
endmodule // tb_event_buffer_word_formatter
